// ===== gcp_command_port.sv
// Target-side two-wire command port of the battery monitor
// Behaviour
// - Answer only to address 1010101
// - Single, incremental, quick reads; single, incremental writes
// - Quick read uses current address pointer
// - Pointer steps on every acknowledged data byte
// - Write bytes land in consecutive locations
// - Not-acknowledge data written to read-only location
// - Not-acknowledge read command above 0x6B
// - Release both lines after 2 s low
// - Still held low after release: sleep
// - Profile status readable at 0x6a, bit 0
// - Status bit 0 names last profile, default 0
// - In sleep, stretch clock up to 4 ms
// - Deep sleep wakes only on own address
`timescale 1ns/1ps
`include "gcp_params.svh"
module gcp_command_port
  import gcp_pkg::*;
#(
  parameter int unsigned STUCK_CYC   = `GCP_STUCK_CYC,
  parameter int unsigned STRETCH_CYC = `GCP_STRETCH_CYC
)(
  input  wire logic       SYS_CLK_IN,      // 100 MHz clock
  input  wire logic       RST_N_IN,        // Async reset, active low
  input  wire logic       SCL_IN,          // Bus clock line level
  output logic            SCL_OE_OUT,      // Pull clock line low
  input  wire logic       SDA_IN,          // Bus data line level
  output logic            SDA_OE_OUT,      // Pull data line low
  input  wire logic       SLEEP_IN,        // Gauge is in sleep power state
  input  wire logic       HIBERNATE_IN,    // Gauge is in deepest power state
  input  wire logic       PROFILE_B_IN,    // Second dynamic profile used last
  input  wire logic [7:0] RD_DATA_IN,      // Data at RD_ADDR_OUT
  input  wire logic       RO_IN,           // Location at RD_ADDR_OUT is read-only
  output logic [7:0]      RD_ADDR_OUT,     // Address pointer
  output logic [7:0]      WR_ADDR_OUT,     // Write location
  output logic [7:0]      WR_DATA_OUT,     // Write data
  output logic            WR_STB_OUT,      // Write strobe, one cycle
  output logic            WAKE_OUT,        // Addressed while hibernating
  output logic            BUS_SLEEP_OUT    // Serial engine asleep
);
  logic scl, sda, scl_rise, scl_fall, start, stop;
  gcp_pin_sync u_sync (
    .clk_in       (SYS_CLK_IN),
    .rst_n_in     (RST_N_IN),
    .scl_in       (SCL_IN),
    .sda_in       (SDA_IN),
    .scl_out      (scl),
    .sda_out      (sda),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start),
    .stop_out     (stop)
  );

  gcp_state_t  st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        rw_q, rw_d;
  logic        cmd_q, cmd_d;
  logic        nak_q, nak_d;
  logic        sda_oe_q, sda_oe_d;
  logic        wstb_q, wstb_d;
  logic [7:0]  wdat_q, wdat_d;
  logic [7:0]  wadr_q, wadr_d;
  logic        wake_q, wake_d;
  logic [31:0] low_q, low_d;
  logic        rel_q, rel_d;
  logic        slp_q, slp_d;
  logic [31:0] str_q, str_d;
  logic        str_oe_q, str_oe_d;
  logic [7:0]  status_q, status_d;
  function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] st, input logic [7:0] ext);
    read_byte = (a == `GCP_STATUS_ADDR) ? st : ext;
  endfunction
  // Status byte: only the selection bit is live
  always_comb begin
    status_d = `GCP_STATUS_RESET;
    status_d[`GCP_STATUS_SEL_BIT] = PROFILE_B_IN;
  end
  // Stuck-bus watch and clock stretch
  always_comb begin
    low_d    = (scl && sda) ? 32'h0 : ((low_q < STUCK_CYC) ? low_q + 32'h1 : low_q);
    rel_d    = rel_q;
    slp_d    = slp_q;
    str_d    = str_q;
    str_oe_d = 1'b0;
    if (low_q == STUCK_CYC - 1) begin
      rel_d = 1'b1;
    end
    if (rel_q && !(scl && sda) && !SCL_OE_OUT && !SDA_OE_OUT) begin
      slp_d = 1'b1;
    end
    if (scl && sda) begin
      rel_d = 1'b0;
      slp_d = 1'b0;
    end
    // Hold the clock low at each clock fall in the address ack state, for any address, so sleep core can respond
    if (SLEEP_IN && st_q == GCP_AACK && scl_fall) begin
      str_d = 32'h1;
    end else if (str_q != 32'h0) begin
      str_d = (str_q >= STRETCH_CYC || !SLEEP_IN) ? 32'h0 : str_q + 32'h1;
    end
    str_oe_d = (str_d != 32'h0) && !rel_d;
  end
  // Protocol engine
  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    rw_d     = rw_q;
    cmd_d    = cmd_q;
    nak_d    = nak_q;
    sda_oe_d = sda_oe_q;
    wstb_d   = 1'b0;
    wdat_d   = wdat_q;
    wadr_d   = wadr_q;
    wake_d   = 1'b0;
    if (start) begin
      st_d     = GCP_ADDR;
      bit_d    = 3'h7;
      sda_oe_d = 1'b0;
      nak_d    = 1'b0;
    end else if (stop || rel_q) begin
      st_d     = GCP_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        GCP_ADDR, GCP_WBYTE: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            if (bit_q == 3'h0) begin
              st_d = (st_q == GCP_ADDR) ? GCP_AACK : GCP_WACK;
            end
            bit_d = bit_q - 3'h1;
          end
        end
        GCP_AACK: begin
          if (scl_fall && !sda_oe_q) begin
            if (sh_q[7:1] == `GCP_DEV_ADDR) begin
              sda_oe_d = 1'b1;
              rw_d     = sh_q[0];
              cmd_d    = ~sh_q[0];
              wake_d   = HIBERNATE_IN;
            end else begin
              st_d = GCP_IGNORE;
            end
          end else if (scl_fall) begin
            bit_d = 3'h7;
            if (rw_q) begin
              st_d     = GCP_RBYTE;
              sh_d     = read_byte(ptr_q, status_q, RD_DATA_IN);
              sda_oe_d = ~read_byte(ptr_q, status_q, RD_DATA_IN) >> 7 != 8'h0;
            end else begin
              st_d     = GCP_WBYTE;
              sda_oe_d = 1'b0;
            end
          end
        end
        GCP_WACK: begin
          if (scl_fall && !sda_oe_q && !nak_q) begin
            if (cmd_q) begin
              ptr_d = sh_q;
              cmd_d = 1'b0;
              nak_d = 1'b0;
              sda_oe_d = 1'b1;
              // Only reads can follow a command above the map; refuse now
              if (sh_q > `GCP_MAX_READ_ADDR) begin
                nak_d    = 1'b1;
                sda_oe_d = 1'b0;
              end
            end else if (RO_IN || ptr_q > `GCP_MAX_READ_ADDR) begin
              nak_d = 1'b1;
            end else begin
              sda_oe_d = 1'b1;
              wstb_d   = 1'b1;
              wadr_d   = ptr_q;
              wdat_d   = sh_q;
              ptr_d    = ptr_q + 8'h1;
            end
          end else if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_d    = 3'h7;
            st_d     = nak_q ? GCP_IGNORE : GCP_WBYTE;
            nak_d    = 1'b0;
          end
        end
        GCP_RBYTE: begin
          if (scl_fall) begin
            if (bit_q == 3'h0) begin
              st_d     = GCP_RACK;
              sda_oe_d = 1'b0;
            end else begin
              sda_oe_d = ~sh_q[6];
              sh_d     = {sh_q[6:0], 1'b0};
            end
            bit_d = bit_q - 3'h1;
          end
        end
        GCP_RACK: begin
          if (scl_rise) begin
            if (!sda) begin
              ptr_d = ptr_q + 8'h1;
            end else begin
              st_d = GCP_IGNORE;
            end
          end else if (scl_fall) begin
            bit_d    = 3'h7;
            st_d     = GCP_RBYTE;
            sh_d     = read_byte(ptr_q, status_q, RD_DATA_IN);
            sda_oe_d = ~read_byte(ptr_q, status_q, RD_DATA_IN) >> 7 != 8'h0;
          end
        end
        default: st_d = st_q;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q     <= GCP_IDLE;
      bit_q    <= 3'h7;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      cmd_q    <= 1'b0;
      nak_q    <= 1'b0;
      sda_oe_q <= 1'b0;
      wstb_q   <= 1'b0;
      wdat_q   <= 8'h00;
      wadr_q   <= 8'h00;
      wake_q   <= 1'b0;
      low_q    <= 32'h0;
      rel_q    <= 1'b0;
      slp_q    <= 1'b0;
      str_q    <= 32'h0;
      str_oe_q <= 1'b0;
      status_q <= `GCP_STATUS_RESET;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      ptr_q    <= ptr_d;
      rw_q     <= rw_d;
      cmd_q    <= cmd_d;
      nak_q    <= nak_d;
      sda_oe_q <= sda_oe_d;
      wstb_q   <= wstb_d;
      wdat_q   <= wdat_d;
      wadr_q   <= wadr_d;
      wake_q   <= wake_d;
      low_q    <= low_d;
      rel_q    <= rel_d;
      slp_q    <= slp_d;
      str_q    <= str_d;
      str_oe_q <= str_oe_d;
      status_q <= status_d;
    end
  end
  always_comb begin
    SDA_OE_OUT    = sda_oe_q & ~rel_q;
    SCL_OE_OUT    = str_oe_q;
    RD_ADDR_OUT   = ptr_q;
    WR_ADDR_OUT   = wadr_q;
    WR_DATA_OUT   = wdat_q;
    WR_STB_OUT    = wstb_q;
    WAKE_OUT      = wake_q;
    BUS_SLEEP_OUT = slp_q;
  end
  property p_write_steps;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN) wstb_d |=> ptr_q == wadr_q + 8'h1;
  endproperty
  a_write_steps: assert property (p_write_steps) else $error("pointer not stepped after write");
  property p_release;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN) rel_q |-> !SDA_OE_OUT && !SCL_OE_OUT;
  endproperty
  a_release: assert property (p_release) else $error("line driven after timeout");
  property p_status_bits;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN) status_q[7:1] == 7'h00;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
  property p_stretch;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN) SCL_OE_OUT |-> SLEEP_IN || $past(SLEEP_IN);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch outside sleep");
  property p_cmd_refuse;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      st_q == GCP_WACK && cmd_q && scl_fall && sh_q > `GCP_MAX_READ_ADDR |=> !SDA_OE_OUT;
  endproperty
  a_cmd_refuse: assert property (p_cmd_refuse) else $error("command above map acknowledged");
  property p_wake_own;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN) WAKE_OUT |-> $past(HIBERNATE_IN) && sh_q[7:1] == `GCP_DEV_ADDR;
  endproperty
  a_wake_own: assert property (p_wake_own) else $error("wake without own address");
  c_write: cover property (@(posedge SYS_CLK_IN) WR_STB_OUT);
  c_release: cover property (@(posedge SYS_CLK_IN) rel_q);
  c_read_ack: cover property (@(posedge SYS_CLK_IN) st_q == GCP_RACK);
endmodule // gcp_command_port

// ===== gcp_params.svh
// Constants for the gauge command port
`ifndef GCP_PARAMS_SVH
`define GCP_PARAMS_SVH
`define GCP_DEV_ADDR        7'h55
`define GCP_MAX_READ_ADDR   8'h6B
`define GCP_STATUS_ADDR     8'h6A
`define GCP_STATUS_RESET    8'h00
`define GCP_STATUS_SEL_BIT  0
`define GCP_RO_LIMIT        8'h60
`define GCP_CLK_MHZ         100
`define GCP_STUCK_MS        2000
`define GCP_STUCK_CYC       (`GCP_STUCK_MS * 1000 * `GCP_CLK_MHZ)
`define GCP_STRETCH_US      4000
`define GCP_STRETCH_CYC     (`GCP_STRETCH_US * `GCP_CLK_MHZ)
`define GCP_WAKE_CYC        16'h0040
`endif

// ===== gcp_pkg.sv
// Types for the gauge command port
package gcp_pkg;
  typedef enum logic [3:0] {
    GCP_IDLE   = 4'b0000,
    GCP_ADDR   = 4'b0001,
    GCP_AACK   = 4'b0010,
    GCP_WBYTE  = 4'b0011,
    GCP_WACK   = 4'b0100,
    GCP_RBYTE  = 4'b0101,
    GCP_RACK   = 4'b0110,
    GCP_IGNORE = 4'b0111
  } gcp_state_t;
endpackage

// ===== gcp_pin_sync.sv
// Two-stage synchroniser and edge finder for the two bus lines
`timescale 1ns/1ps
module gcp_pin_sync
  import gcp_pkg::*;
(
  input  wire logic clk_in,       // System clock
  input  wire logic rst_n_in,     // Async reset, active low
  input  wire logic scl_in,       // Raw clock line
  input  wire logic sda_in,       // Raw data line
  output logic      scl_out,      // Synchronised clock line
  output logic      sda_out,      // Synchronised data line
  output logic      scl_rise_out, // Clock line rose
  output logic      scl_fall_out, // Clock line fell
  output logic      start_out,    // Start or repeated start
  output logic      stop_out      // Stop condition
);
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  always_comb begin
    scl_out      = scl_s_q[1];
    sda_out      = sda_s_q[1];
    scl_rise_out = scl_s_q[1] & ~scl_p_q;
    scl_fall_out = ~scl_s_q[1] & scl_p_q;
    start_out    = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    stop_out     = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
  end
endmodule // gcp_pin_sync

// ===== gcp_host_model.sv
// Bus controller model driving the two-wire lines of the command port
`timescale 1ns/1ps
module gcp_host_model (
  input  wire logic scl_in,      // Clock line level
  input  wire logic sda_in,      // Data line level
  output logic      scl_low_out, // Pull clock line low
  output logic      sda_low_out  // Pull data line low
);
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic q();
    #31.25;
  endtask
  // Target may stretch, so wait on the line itself
  task automatic rise();
    scl_low_out <= 1'b0;
    for (int i = 0; i < 4000 && scl_in !== 1'b1; i++) #10;
    q();
  endtask
  // Four quarters per bit: 62.5 ns low, 62.5 ns high, sampled late in the high phase
  task automatic pulse(input logic b, output logic r);
    sda_low_out <= ~b;
    q();
    rise();
    q();
    r = sda_in;
    scl_low_out <= 1'b1;
    q();
  endtask
  task automatic start();
    sda_low_out <= 1'b0;
    q();
    rise();
    sda_low_out <= 1'b1;
    q();
    scl_low_out <= 1'b1;
    q();
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    q();
    rise();
    sda_low_out <= 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(b[i], r);
    pulse(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(~ack, r);
  endtask
endmodule // gcp_host_model

// ===== tb_gcp_command_port.sv
// Self-checking bench for the gauge command port
`timescale 1ns/1ps
module tb_gcp_command_port;
  import gcp_pkg::*;
  localparam int unsigned STUCK   = 2000;
  localparam int unsigned STRETCH = 500;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sleep = 1'b0;
  logic       hib = 1'b0;
  logic       prof_b = 1'b0;
  logic       ro = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic       scl_oe, sda_oe, wr_stb, wake, bus_sleep, h_scl, h_sda;
  logic [7:0] rd_addr, wr_addr, wr_data;
  logic [15:0] wlog[$];
  int         bad_count = 0;
  int         n_compared = 0;
  int         n_wake = 0;
  int         run = 0;
  int         max_run = 0;
  // Open-drain lines with pull-ups
  wire scl = ~(scl_oe | h_scl);
  wire sda = ~(sda_oe | h_sda);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    rd_data <= rd_addr ^ 8'h5A;
    ro <= (rd_addr == 8'h30) | (wr_addr == 8'h30);
    if (wr_stb === 1'b1) wlog.push_back({wr_addr, wr_data});
    if (wake === 1'b1) n_wake++;
    run <= (scl_oe === 1'b1) ? run + 1 : 0;
    if (run > max_run) max_run = run;
  end
  gcp_command_port #(.STUCK_CYC(STUCK), .STRETCH_CYC(STRETCH)) i_dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SCL_OE_OUT(scl_oe), .SDA_IN(sda),
    .SDA_OE_OUT(sda_oe), .SLEEP_IN(sleep), .HIBERNATE_IN(hib), .PROFILE_B_IN(prof_b),
    .RD_DATA_IN(rd_data), .RO_IN(ro), .RD_ADDR_OUT(rd_addr), .WR_ADDR_OUT(wr_addr),
    .WR_DATA_OUT(wr_data), .WR_STB_OUT(wr_stb), .WAKE_OUT(wake), .BUS_SLEEP_OUT(bus_sleep));
  gcp_host_model i_host (.scl_in(scl), .sda_in(sda), .scl_low_out(h_scl), .sda_low_out(h_sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic sel(input logic [7:0] cmd, output logic a0, output logic a1);
    i_host.start();
    i_host.wbyte(8'hAA, a0);
    i_host.wbyte(cmd, a1);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic ack, output logic [7:0] d);
    logic a0, a1, a2;
    sel(cmd, a0, a1);
    i_host.start();
    i_host.wbyte(8'hAB, a2);
    i_host.rbyte(ack, d);
  endtask
  task automatic t_status();
    logic [7:0] d;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) prof_b <= p[0];
      rd(8'h6A, 1'b0, d);
      i_host.stop();
      chk(16'(d), {15'h0000, p[0]});
    end
  endtask
  task automatic t_write();
    logic a0, a1, a2, a3;
    wlog.delete();
    sel(8'h10, a0, a1);
    i_host.wbyte(8'h11, a2);
    i_host.wbyte(8'h22, a3);
    i_host.stop();
    chk({a0, a1, a2, a3}, 16'h000F);
    chk({wlog[0][15:8], wlog[1][15:8]}, 16'h1011);
    chk({wlog[0][7:0], wlog[1][7:0]}, 16'h1122);
    chk(16'(rd_addr), 16'h0012);
  endtask
  task automatic t_read();
    logic a0;
    logic [7:0] d0, d1, d2;
    rd(8'h20, 1'b1, d0);
    i_host.rbyte(1'b0, d1);
    i_host.stop();
    i_host.start();
    i_host.wbyte(8'hAB, a0);
    i_host.rbyte(1'b0, d2);
    i_host.stop();
    chk({d0, d1}, 16'h7A7B);
    chk({a0, d2}, 16'h017B);
    chk(16'(rd_addr), 16'h0021);
  endtask
  task automatic t_refuse();
    logic a0, a1, a2;
    wlog.delete();
    sel(8'h30, a0, a1);
    i_host.wbyte(8'h33, a2);
    i_host.stop();
    chk({a0, a1, a2}, 16'h0006);
    sel(8'h6B, a0, a1);
    i_host.stop();
    chk(16'(a1), 16'h0001);
    sel(8'h6C, a0, a1);
    i_host.stop();
    chk(16'(a1), 16'h0000);
    i_host.start();
    i_host.wbyte(8'hA8, a0);
    i_host.stop();
    chk({a0, 15'(wlog.size())}, 16'h0000);
  endtask
  task automatic t_wake();
    logic a0;
    @(posedge clk) hib <= 1'b1;
    n_wake = 0;
    i_host.start();
    i_host.wbyte(8'hA8, a0);
    i_host.stop();
    chk(16'(n_wake), 16'h0000);
    i_host.start();
    i_host.wbyte(8'hAA, a0);
    i_host.stop();
    chk(16'(n_wake), 16'h0001);
    @(posedge clk) hib <= 1'b0;
  endtask
  task automatic t_stretch();
    logic a0, a1;
    @(posedge clk) sleep <= 1'b1;
    max_run = 0;
    sel(8'h10, a0, a1);
    i_host.stop();
    @(posedge clk) sleep <= 1'b0;
    chk(16'(max_run + 8 >= STRETCH && max_run <= STRETCH + 8), 16'h0001);
  endtask
  // Host keeps the clock line low after the address, with the ack driven
  task automatic t_stuck();
    logic r;
    int i;
    i_host.start();
    for (i = 0; i < 8; i++) i_host.pulse(~i[0], r);
    i_host.sda_low_out <= 1'b0;
    for (i = 0; i < 3 * STUCK && sda_oe !== 1'b1; i++) @(posedge clk);
    for (i = 0; i < 2 * STUCK && sda_oe === 1'b1; i++) @(posedge clk);
    chk(16'(i + 16 >= STUCK && i <= STUCK + 16 && scl_oe === 1'b0), 16'h0001);
    for (i = 0; i < 2 * STUCK && bus_sleep !== 1'b1; i++) @(posedge clk);
    chk(16'(bus_sleep), 16'h0001);
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_status();
    t_write();
    t_read();
    t_refuse();
    t_wake();
    t_stretch();
    t_stuck();
    finish_test();
  end
  // Whole sequence needs roughly 100 us; four times that is ample
  initial begin
    #400000;
    $display("[ERR] %0t: watchdog expired", $time);
    bad_count++;
    finish_test();
  end
endmodule // tb_gcp_command_port
